//--- common/pause_ptp_regs.svh
// Purpose: Named constants for the TX pause and timestamp sideband
// Assumes: 200 MHz mclk
// Notes: Included by the package, the interface and both ends
`ifndef PAUSE_PTP_REGS_SVH
`define PAUSE_PTP_REGS_SVH

`define PAUSE_CHANNELS 9
`define PAUSE_GLOBAL_IDX 8
`define PAUSE_IDX_W 4
`define PAUSE_WORD_W 16
`define PAUSE_HOLD_CYCLES 16
`define TIME_W 80
`define LANE_W 5
`define LANE_COUNT 20
`define TAG_W 16
`define OP_W 2
`define OP_NONE 2'h0
`define OP_ONE_STEP 2'h1
`define OP_TWO_STEP 2'h2
`define OP_RESERVED 2'h3
`define OC_SEC_W 48
`define OC_NS_W 32
`define TC_SIGN_BIT 63
`define TC_NS_HI 62
`define TC_NS_LO 16
`define TC_FRAC_W 16
`define CLK_PERIOD_NS 5
`define NS_PER_SEC 32'h3B9ACA00
`define STAMP_QUEUE_DEPTH 4

`endif

//--- common/pause_ptp_pkg.sv
// Purpose: Types and time-format helpers shared by both ends
// Assumes: Constants come from pause_ptp_regs.svh
// Notes: Ordinary layout is seconds over nanoseconds; transparent is sign, ns, fraction
`default_nettype none
`include "pause_ptp_regs.svh"

package pause_ptp_pkg;

    typedef logic [`PAUSE_WORD_W-1:0] word_t;
    typedef logic [`PAUSE_CHANNELS-1:0] pause_vec_t;
    typedef logic [`PAUSE_CHANNELS-1:0][`PAUSE_WORD_W-1:0] word_array_t;
    typedef logic [`TIME_W-1:0] sys_time_t;
    typedef logic [`TAG_W-1:0] tag_t;
    typedef logic [`LANE_W-1:0] lane_t;
    typedef logic [`OP_W-1:0] op_t;

    // Ordinary clock: seconds in the upper 48 bits, nanoseconds in the lower 32
    function automatic sys_time_t pack_ordinary(input logic [`OC_SEC_W-1:0] sec,
                                                input logic [`OC_NS_W-1:0] ns);
        pack_ordinary = {sec, ns};
    endfunction : pack_ordinary

    // Transparent clock: sign, nanoseconds and fraction in the lower 64 bits
    function automatic sys_time_t pack_transparent(input logic sign,
                                                   input logic [`TC_NS_HI-`TC_NS_LO:0] ns,
                                                   input logic [`TC_FRAC_W-1:0] frac);
        pack_transparent = '0;
        pack_transparent[`TC_SIGN_BIT] = sign;
        pack_transparent[`TC_NS_HI:`TC_NS_LO] = ns;
        pack_transparent[`TC_FRAC_W-1:0] = frac;
    endfunction : pack_transparent

    // Timestamp ops that ask for a capture
    function automatic logic op_stamps(input op_t op);
        op_stamps = (op == `OP_ONE_STEP) || (op == `OP_TWO_STEP);
    endfunction : op_stamps

endpackage : pause_ptp_pkg

`default_nettype wire

//--- common/pause_ptp_if.sv
// Purpose: Sideband between client transmit logic and the MAC TX control
// Assumes: Every signal is synchronous to mclk
// Notes: Client drives requests, time and frame ops; device drives status and stamps
`timescale 1ns/1ps
`default_nettype none
`include "pause_ptp_regs.svh"

interface pause_ptp_if;
    pause_ptp_pkg::pause_vec_t pause_request_bits;
    pause_ptp_pkg::word_array_t pause_quanta_value;
    pause_ptp_pkg::word_array_t pause_refresh_interval;
    logic force_pause_resend;
    pause_ptp_pkg::pause_vec_t pause_sent;
    pause_ptp_pkg::sys_time_t tx_system_time;
    logic frame_accept;
    pause_ptp_pkg::op_t frame_timestamp_op;
    pause_ptp_pkg::tag_t frame_tag;
    logic timestamp_valid;
    pause_ptp_pkg::lane_t timestamp_lane_index;
    pause_ptp_pkg::tag_t timestamp_tag_return;
    pause_ptp_pkg::sys_time_t captured_timestamp;

    modport device (
        input pause_request_bits,
        input pause_quanta_value,
        input pause_refresh_interval,
        input force_pause_resend,
        output pause_sent,
        input tx_system_time,
        input frame_accept,
        input frame_timestamp_op,
        input frame_tag,
        output timestamp_valid,
        output timestamp_lane_index,
        output timestamp_tag_return,
        output captured_timestamp
    );

    modport client (
        output pause_request_bits,
        output pause_quanta_value,
        output pause_refresh_interval,
        output force_pause_resend,
        input pause_sent,
        output tx_system_time,
        output frame_accept,
        output frame_timestamp_op,
        output frame_tag,
        input timestamp_valid,
        input timestamp_lane_index,
        input timestamp_tag_return,
        input captured_timestamp
    );
endinterface : pause_ptp_if

`default_nettype wire

//--- logic/pause_ptp_device.sv
// Purpose: MAC TX sideband: pause refresh/resend scheduling and PTP stamp return
// Assumes: Datapath reports in-flight frames and start-of-frame at the capture plane
// Notes: Refresh intervals count mclk cycles; one pause packet issued per idle cycle
`timescale 1ns/1ps
`default_nettype none
`include "pause_ptp_regs.svh"

module pause_ptp_device #(
    parameter int QUEUE_DEPTH = `STAMP_QUEUE_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    pause_ptp_if.device link,
    input wire logic line_busy,
    input wire logic sop_capture,
    input wire logic [`LANE_W-1:0] sop_lane,
    output logic pause_emit,
    output logic [`PAUSE_IDX_W-1:0] pause_emit_index,
    output logic [`PAUSE_WORD_W-1:0] pause_emit_quanta,
    output logic stamp_insert,
    output logic stamp_overflow
);

    localparam int PTR_W = $clog2(QUEUE_DEPTH);

    // Lowest pending channel wins the next idle slot
    function automatic logic [`PAUSE_IDX_W-1:0] lowest_set(input pause_ptp_pkg::pause_vec_t v);
        lowest_set = '0;
        for (int i = `PAUSE_CHANNELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowest_set = `PAUSE_IDX_W'(i);
            end
        end
    endfunction : lowest_set

    pause_ptp_pkg::pause_vec_t req_prev_ff;
    pause_ptp_pkg::pause_vec_t pending_ff;
    pause_ptp_pkg::pause_vec_t nxt_pending;
    pause_ptp_pkg::pause_vec_t set_vec;
    pause_ptp_pkg::pause_vec_t emit_mask;
    pause_ptp_pkg::pause_vec_t expire;
    pause_ptp_pkg::pause_vec_t rise;
    pause_ptp_pkg::word_array_t refresh_cnt_ff;
    pause_ptp_pkg::word_array_t nxt_refresh_cnt;
    logic do_emit;
    logic [`PAUSE_IDX_W-1:0] emit_idx;
    logic pause_emit_ff;
    logic [`PAUSE_IDX_W-1:0] pause_emit_index_ff;
    logic [`PAUSE_WORD_W-1:0] pause_emit_quanta_ff;
    pause_ptp_pkg::pause_vec_t pause_sent_ff;

    // Pause scheduling
    always_comb begin
        rise = link.pause_request_bits & ~req_prev_ff;
        for (int i = 0; i < `PAUSE_CHANNELS; i++) begin
            expire[i] = link.pause_request_bits[i] && !rise[i] &&
                        (link.pause_refresh_interval[i] != '0) &&
                        (refresh_cnt_ff[i] >= link.pause_refresh_interval[i]);
        end
        set_vec = rise | expire;
        if (link.force_pause_resend) begin
            set_vec = set_vec | link.pause_request_bits;
        end
        do_emit = !line_busy && (pending_ff != '0);
        emit_idx = lowest_set(pending_ff);
        emit_mask = '0;
        if (do_emit) begin
            emit_mask[emit_idx] = 1'b1;
        end
        nxt_pending = (pending_ff & ~emit_mask) | set_vec;
        for (int i = 0; i < `PAUSE_CHANNELS; i++) begin
            if (!link.pause_request_bits[i] || rise[i] || expire[i] || link.force_pause_resend) begin
                nxt_refresh_cnt[i] = '0;
            end else if (refresh_cnt_ff[i] != '1) begin
                nxt_refresh_cnt[i] = refresh_cnt_ff[i] + `PAUSE_WORD_W'(1);
            end else begin
                nxt_refresh_cnt[i] = refresh_cnt_ff[i];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_prev_ff <= '0;
            pending_ff <= '0;
            refresh_cnt_ff <= '0;
        end else begin
            req_prev_ff <= link.pause_request_bits;
            pending_ff <= nxt_pending;
            refresh_cnt_ff <= nxt_refresh_cnt;
        end
    end

    // Pause packet issue and sent status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pause_emit_ff <= 1'b0;
            pause_emit_index_ff <= '0;
            pause_emit_quanta_ff <= '0;
            pause_sent_ff <= '0;
        end else begin
            pause_emit_ff <= do_emit;
            pause_sent_ff <= emit_mask;
            if (do_emit) begin
                pause_emit_index_ff <= emit_idx;
                pause_emit_quanta_ff <= link.pause_quanta_value[emit_idx];
            end
        end
    end

    // Timestamp op queue, one entry per accepted frame
    pause_ptp_pkg::op_t q_op [QUEUE_DEPTH];
    pause_ptp_pkg::tag_t q_tag [QUEUE_DEPTH];
    logic [PTR_W:0] wr_ptr_ff;
    logic [PTR_W:0] rd_ptr_ff;
    logic q_empty;
    logic q_full;
    logic do_push;
    logic do_pop;
    pause_ptp_pkg::op_t head_op;
    pause_ptp_pkg::tag_t head_tag;

    always_comb begin
        q_empty = (wr_ptr_ff == rd_ptr_ff);
        q_full = (wr_ptr_ff[PTR_W-1:0] == rd_ptr_ff[PTR_W-1:0]) && (wr_ptr_ff[PTR_W] != rd_ptr_ff[PTR_W]);
        do_pop = sop_capture && !q_empty;
        do_push = link.frame_accept && (!q_full || do_pop);
        head_op = q_op[rd_ptr_ff[PTR_W-1:0]];
        head_tag = q_tag[rd_ptr_ff[PTR_W-1:0]];
    end

    always_ff @(posedge mclk) begin
        if (do_push) begin
            q_op[wr_ptr_ff[PTR_W-1:0]] <= link.frame_timestamp_op;
            q_tag[wr_ptr_ff[PTR_W-1:0]] <= link.frame_tag;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + (PTR_W + 1)'(1);
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_ptr_ff + (PTR_W + 1)'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stamp_overflow <= 1'b0;
        end else if (link.frame_accept && q_full && !do_pop) begin
            stamp_overflow <= 1'b1;
        end
    end

    // Capture and return
    logic ts_valid_ff;
    logic stamp_insert_ff;
    pause_ptp_pkg::lane_t ts_lane_ff;
    pause_ptp_pkg::tag_t ts_tag_ff;
    pause_ptp_pkg::sys_time_t ts_time_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ts_valid_ff <= 1'b0;
            stamp_insert_ff <= 1'b0;
        end else begin
            ts_valid_ff <= do_pop && pause_ptp_pkg::op_stamps(head_op);
            stamp_insert_ff <= do_pop && (head_op == `OP_ONE_STEP);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ts_lane_ff <= '0;
            ts_tag_ff <= '0;
            ts_time_ff <= '0;
        end else if (do_pop && pause_ptp_pkg::op_stamps(head_op)) begin
            ts_lane_ff <= sop_lane;
            ts_tag_ff <= head_tag;
            ts_time_ff <= link.tx_system_time;
        end
    end

    assign link.pause_sent = pause_sent_ff;
    assign link.timestamp_valid = ts_valid_ff;
    assign link.timestamp_lane_index = ts_lane_ff;
    assign link.timestamp_tag_return = ts_tag_ff;
    assign link.captured_timestamp = ts_time_ff;
    assign pause_emit = pause_emit_ff;
    assign pause_emit_index = pause_emit_index_ff;
    assign pause_emit_quanta = pause_emit_quanta_ff;
    assign stamp_insert = stamp_insert_ff;

endmodule : pause_ptp_device

`default_nettype wire

//--- logic/pause_ptp_client.sv
// Purpose: Client TX sideband: pause requests, resend pulse, system time, frame ops
// Assumes: Same mclk as the MAC side
// Notes: Pause request changes are paced to the minimum hold time
`timescale 1ns/1ps
`default_nettype none
`include "pause_ptp_regs.svh"

module pause_ptp_client (
    input wire logic mclk,
    input wire logic rst,
    pause_ptp_if.client link,
    input wire logic [`PAUSE_CHANNELS-1:0] want_pause,
    input wire logic [`PAUSE_CHANNELS-1:0][`PAUSE_WORD_W-1:0] quanta_in,
    input wire logic [`PAUSE_CHANNELS-1:0][`PAUSE_WORD_W-1:0] interval_in,
    input wire logic resend_level,
    input wire logic transparent_mode,
    input wire logic send_frame,
    input wire logic [`OP_W-1:0] send_op,
    input wire logic [`TAG_W-1:0] send_tag,
    output logic stamp_ready,
    output logic [`TAG_W-1:0] stamp_tag,
    output logic [`LANE_W-1:0] stamp_lane,
    output logic [`TIME_W-1:0] stamp_time,
    output logic [`PAUSE_CHANNELS-1:0] sent_seen
);

    localparam int HOLD_W = $clog2(`PAUSE_HOLD_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(`PAUSE_HOLD_CYCLES - 1);
    localparam int TC_NS_W = `TC_NS_HI - `TC_NS_LO + 1;

    pause_ptp_pkg::pause_vec_t req_ff;
    logic [`PAUSE_CHANNELS-1:0][HOLD_W-1:0] hold_cnt_ff;
    pause_ptp_pkg::word_array_t quanta_ff;
    pause_ptp_pkg::word_array_t interval_ff;
    logic resend_prev_ff;
    logic resend_ff;

    // Each request bit changes only after a full hold time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_ff <= '0;
            hold_cnt_ff <= '0;
        end else begin
            for (int i = 0; i < `PAUSE_CHANNELS; i++) begin
                if (hold_cnt_ff[i] != HOLD_LAST) begin
                    hold_cnt_ff[i] <= hold_cnt_ff[i] + HOLD_W'(1);
                end else if (want_pause[i] != req_ff[i]) begin
                    req_ff[i] <= want_pause[i];
                    hold_cnt_ff[i] <= '0;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            quanta_ff <= '0;
            interval_ff <= '0;
        end else begin
            quanta_ff <= quanta_in;
            interval_ff <= interval_in;
        end
    end

    // Resend level turned into a single-cycle pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resend_prev_ff <= 1'b0;
            resend_ff <= 1'b0;
        end else begin
            resend_prev_ff <= resend_level;
            resend_ff <= resend_level && !resend_prev_ff;
        end
    end

    // System time kept on mclk, in either layout
    logic [`OC_SEC_W-1:0] sec_ff;
    logic [`OC_NS_W-1:0] ns_ff;
    logic [TC_NS_W-1:0] tc_ns_ff;
    pause_ptp_pkg::sys_time_t time_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sec_ff <= '0;
            ns_ff <= '0;
            tc_ns_ff <= '0;
        end else begin
            tc_ns_ff <= tc_ns_ff + TC_NS_W'(`CLK_PERIOD_NS);
            if (ns_ff >= `NS_PER_SEC - `OC_NS_W'(`CLK_PERIOD_NS)) begin
                ns_ff <= ns_ff + `OC_NS_W'(`CLK_PERIOD_NS) - `NS_PER_SEC;
                sec_ff <= sec_ff + `OC_SEC_W'(1);
            end else begin
                ns_ff <= ns_ff + `OC_NS_W'(`CLK_PERIOD_NS);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            time_ff <= '0;
        end else if (transparent_mode) begin
            time_ff <= pause_ptp_pkg::pack_transparent(1'b0, tc_ns_ff, '0);
        end else begin
            time_ff <= pause_ptp_pkg::pack_ordinary(sec_ff, ns_ff);
        end
    end

    // Frame op and tag, one cycle per frame
    logic frame_ff;
    pause_ptp_pkg::op_t op_ff;
    pause_ptp_pkg::tag_t tag_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_ff <= 1'b0;
            op_ff <= `OP_NONE;
            tag_ff <= '0;
        end else begin
            frame_ff <= send_frame;
            if (send_frame) begin
                op_ff <= (send_op == `OP_RESERVED) ? `OP_NONE : send_op;
                tag_ff <= send_tag;
            end
        end
    end

    // Returned stamps and pause status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stamp_ready <= 1'b0;
            stamp_tag <= '0;
            stamp_lane <= '0;
            stamp_time <= '0;
            sent_seen <= '0;
        end else begin
            stamp_ready <= link.timestamp_valid;
            sent_seen <= link.pause_sent;
            if (link.timestamp_valid) begin
                stamp_tag <= link.timestamp_tag_return;
                stamp_lane <= link.timestamp_lane_index;
                stamp_time <= link.captured_timestamp;
            end
        end
    end

    assign link.pause_request_bits = req_ff;
    assign link.pause_quanta_value = quanta_ff;
    assign link.pause_refresh_interval = interval_ff;
    assign link.force_pause_resend = resend_ff;
    assign link.tx_system_time = time_ff;
    assign link.frame_accept = frame_ff;
    assign link.frame_timestamp_op = op_ff;
    assign link.frame_tag = tag_ff;

endmodule : pause_ptp_client

`default_nettype wire

//--- sim/pause_ptp_props.sv
// Purpose: Assertions on the pause and timestamp sideband
// Assumes: One mclk domain, rst active high
// Notes: Instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none

module pause_ptp_props (
    input wire logic mclk,
    input wire logic rst,
    input wire pause_ptp_pkg::pause_vec_t pause_request_bits,
    input wire logic force_pause_resend,
    input wire pause_ptp_pkg::pause_vec_t pause_sent,
    input wire pause_ptp_pkg::sys_time_t tx_system_time,
    input wire logic frame_accept,
    input wire pause_ptp_pkg::op_t frame_timestamp_op,
    input wire pause_ptp_pkg::tag_t frame_tag,
    input wire logic timestamp_valid,
    input wire pause_ptp_pkg::lane_t timestamp_lane_index,
    input wire pause_ptp_pkg::tag_t timestamp_tag_return,
    input wire pause_ptp_pkg::sys_time_t captured_timestamp
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic [15:0] tags_ff [16];
    logic [3:0] wr_ff;
    logic [3:0] rd_ff;
    logic push;
    assign push = frame_accept && (frame_timestamp_op == 2'h1 || frame_timestamp_op == 2'h2);
    // Tags of stamping frames in acceptance order
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ff <= 4'h0;
            rd_ff <= 4'h0;
        end else begin
            wr_ff <= wr_ff + 4'(push);
            rd_ff <= rd_ff + 4'(timestamp_valid);
        end
    end
    always_ff @(posedge mclk) begin
        if (push) begin
            tags_ff[wr_ff] <= frame_tag;
        end
    end
    property p_sent_one;
        pause_sent != 9'h000 |-> $onehot(pause_sent);
    endproperty
    a_sent_one: assert property (p_sent_one) else $error("several pause bits at once");
    property p_rise_sent;
        $rose(pause_request_bits[8]) |-> ##[1:64] pause_sent[8];
    endproperty
    a_rise_sent: assert property (p_rise_sent) else $error("global pause not sent");
    property p_req_hold;
        $changed(pause_request_bits[8]) |=> $stable(pause_request_bits[8])[*8] ##1 $stable(pause_request_bits[8])[*7];
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed too soon");
    property p_resend_pulse;
        force_pause_resend |=> !force_pause_resend;
    endproperty
    a_resend_pulse: assert property (p_resend_pulse) else $error("resend longer than one cycle");
    property p_tag_order;
        timestamp_valid |-> wr_ff != rd_ff && timestamp_tag_return == tags_ff[rd_ff];
    endproperty
    a_tag_order: assert property (p_tag_order) else $error("stamp tag out of order");
    property p_stamp_time;
        timestamp_valid |-> captured_timestamp == $past(tx_system_time);
    endproperty
    a_stamp_time: assert property (p_stamp_time) else $error("stamp time wrong");
    property p_lane_range;
        timestamp_valid |-> timestamp_lane_index < 5'h14;
    endproperty
    a_lane_range: assert property (p_lane_range) else $error("lane index out of range");
    property p_stamp_hold;
        !timestamp_valid |-> $stable(captured_timestamp) && $stable(timestamp_tag_return);
    endproperty
    a_stamp_hold: assert property (p_stamp_hold) else $error("stamp changed without valid");
endmodule : pause_ptp_props

`default_nettype wire

//--- sim/tx_pause_ptp_timestamp_test.sv
// Purpose: Drives both ends of the sideband and checks results
// Assumes: 200 MHz mclk, inputs change 1 ns after the edge
// Notes: Monitor queues record issued pauses and returned stamps
`timescale 1ns/1ps
`default_nettype none
`include "pause_ptp_regs.svh"

module tx_pause_ptp_timestamp_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [8:0] want = 9'h000;
    logic [8:0][15:0] quanta;
    logic [8:0][15:0] ival;
    logic resend = 1'b0;
    logic tmode = 1'b0;
    logic send = 1'b0;
    logic [1:0] op = 2'h0;
    logic [15:0] tag = 16'h0000;
    logic busy = 1'b0;
    logic sop = 1'b0;
    logic [4:0] lane = 5'h00;
    logic emit;
    logic ins;
    logic [3:0] e_idx;
    logic [15:0] e_q;
    logic [15:0] r_tag;
    logic ovf;
    logic rdy;
    logic [8:0] seen;
    logic [4:0] r_lane;
    logic [79:0] r_time;
    int s_cyc[$];
    logic [3:0] s_ch[$];
    logic [15:0] s_q[$];
    logic [15:0] t_tag[$];
    logic [4:0] t_lane[$];
    logic [79:0] t_time[$];
    logic t_ins[$];
    logic [79:0] p_time[$];

    pause_ptp_if bus();
    pause_ptp_device pause_ptp_device_inst (.mclk(mclk), .rst(rst), .link(bus), .line_busy(busy),
        .sop_capture(sop), .sop_lane(lane), .pause_emit(emit), .pause_emit_index(e_idx),
        .pause_emit_quanta(e_q), .stamp_insert(ins), .stamp_overflow(ovf));
    pause_ptp_client pause_ptp_client_inst (.mclk(mclk), .rst(rst), .link(bus), .want_pause(want),
        .quanta_in(quanta), .interval_in(ival), .resend_level(resend), .transparent_mode(tmode),
        .send_frame(send), .send_op(op), .send_tag(tag), .stamp_ready(rdy), .stamp_tag(r_tag),
        .stamp_lane(r_lane), .stamp_time(r_time), .sent_seen(seen));
    pause_ptp_props pause_ptp_props_inst (.mclk(mclk), .rst(rst),
        .pause_request_bits(bus.pause_request_bits), .force_pause_resend(bus.force_pause_resend),
        .pause_sent(bus.pause_sent), .tx_system_time(bus.tx_system_time), .frame_accept(bus.frame_accept),
        .frame_timestamp_op(bus.frame_timestamp_op), .frame_tag(bus.frame_tag),
        .timestamp_valid(bus.timestamp_valid), .timestamp_lane_index(bus.timestamp_lane_index),
        .timestamp_tag_return(bus.timestamp_tag_return), .captured_timestamp(bus.captured_timestamp));

    always #2.5 mclk = ~mclk;

    task chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        n_tests++;
        if (exp !== got) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Records issued pauses, returned stamps and time at each frame start
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (emit === 1'b1) begin
            s_cyc.push_back(cyc);
            s_ch.push_back(e_idx);
            s_q.push_back(e_q);
            chk("sent bit", 80'(9'h001 << e_idx), 80'(bus.pause_sent));
        end
        if (bus.timestamp_valid === 1'b1) begin
            t_tag.push_back(bus.timestamp_tag_return);
            t_lane.push_back(bus.timestamp_lane_index);
            t_time.push_back(bus.captured_timestamp);
            t_ins.push_back(ins);
        end
        if (sop === 1'b1) begin
            p_time.push_back(bus.tx_system_time);
        end
    end

    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task clr;
        s_cyc.delete();
        s_ch.delete();
        s_q.delete();
        t_tag.delete();
        t_lane.delete();
        t_time.delete();
        t_ins.delete();
        p_time.delete();
    endtask : clr

    task wait_sent(input int lim);
        for (int i = 0; i < lim && s_ch.size() == 0; i++) begin
            tick(1);
        end
        if (s_ch.size() == 0) begin
            chk("pause issued", 80'h1, 80'h0);
        end
    endtask : wait_sent

    task pause_one(input int n);
        clr();
        want = 9'h001 << n;
        wait_sent(60);
        chk("index", 80'(n), 80'(s_ch[0]));
        chk("quanta", 80'(quanta[n]), 80'(s_q[0]));
        chk("sent seen", 80'(9'h001 << n), 80'(seen));
        tick(20);
        chk("one packet", 80'h1, 80'(s_ch.size()));
    endtask : pause_one

    task refresh(input int n, input int iv);
        int c0;
        ival[n] = 16'(iv);
        clr();
        want = 9'h001 << n;
        wait_sent(60);
        c0 = s_cyc[0];
        clr();
        wait_sent(iv + 10);
        chk("period", 80'(iv + 1), 80'(s_cyc[0] - c0));
        tick(iv / 2);
        clr();
        resend = 1'b1;
        tick(1);
        resend = 1'b0;
        wait_sent(8);
        c0 = s_cyc[0];
        clr();
        wait_sent(iv + 10);
        chk("period after resend", 80'(iv + 1), 80'(s_cyc[0] - c0));
        ival[n] = 16'h0000;
        want = 9'h000;
        tick(30);
    endtask : refresh

    task busy_resend;
        clr();
        busy = 1'b1;
        want = 9'h004;
        tick(30);
        chk("held while busy", 80'h0, 80'(s_ch.size()));
        busy = 1'b0;
        wait_sent(6);
        clr();
        busy = 1'b1;
        resend = 1'b1;
        tick(1);
        resend = 1'b0;
        tick(10);
        chk("resend waits", 80'h0, 80'(s_ch.size()));
        busy = 1'b0;
        wait_sent(6);
        chk("resend index", 80'h2, 80'(s_ch[0]));
        want = 9'h000;
        tick(20);
    endtask : busy_resend

    task stamp_ops;
        for (int k = 0; k < 4; k++) begin
            clr();
            send = 1'b1;
            op = 2'(k);
            tag = 16'hA500 + 16'(k);
            tick(1);
            send = 1'b0;
            tick(2);
            sop = 1'b1;
            lane = 5'(k * 6 + 1);
            tick(1);
            sop = 1'b0;
            tick(1);
            chk("ready", 80'(k == 1 || k == 2), 80'(rdy));
            tick(3);
            if (k == 1 || k == 2) begin
                chk("tag", 80'(tag), 80'(t_tag[0]));
                chk("lane", 80'(lane), 80'(t_lane[0]));
                chk("time", p_time[0], t_time[0]);
                chk("insert", 80'(k == 1), 80'(t_ins[0]));
                chk("client tag", 80'(tag), 80'(r_tag));
                chk("client lane", 80'(lane), 80'(r_lane));
                chk("client time", p_time[0], r_time);
                chk("ns range", 80'h1, 80'(t_time[0][31:0] < `NS_PER_SEC));
            end else begin
                chk("no stamp", 80'h0, 80'(t_tag.size()));
            end
        end
    endtask : stamp_ops

    task stamp_b2b;
        clr();
        tmode = 1'b1;
        tick(4);
        send = 1'b1;
        op = 2'h2;
        tag = 16'h0B01;
        tick(1);
        op = 2'h1;
        tag = 16'h0B02;
        tick(1);
        send = 1'b0;
        tick(1);
        sop = 1'b1;
        lane = 5'h03;
        tick(1);
        lane = 5'h13;
        tick(1);
        sop = 1'b0;
        tick(4);
        chk("stamps", 80'h2, 80'(t_tag.size()));
        chk("first tag", 80'h0B01, 80'(t_tag[0]));
        chk("second tag", 80'h0B02, 80'(t_tag[1]));
        chk("second lane", 80'h13, 80'(t_lane[1]));
        chk("second time", p_time[1], t_time[1]);
        chk("upper bits", 80'h0, 80'(t_time[1][79:64]));
        clr();
        sop = 1'b1;
        tick(1);
        sop = 1'b0;
        tick(4);
        chk("empty pop", 80'h0, 80'(t_tag.size()));
        chk("no overflow", 80'h0, 80'(ovf));
        send = 1'b1;
        op = 2'h0;
        tick(5);
        send = 1'b0;
        tick(2);
        chk("overflow", 80'h1, 80'(ovf));
        sop = 1'b1;
        tick(4);
        sop = 1'b0;
        tick(2);
    endtask : stamp_b2b

    task conclude;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    initial begin
        for (int i = 0; i < 9; i++) begin
            quanta[i] = 16'h1100 + 16'(i);
            ival[i] = 16'h0000;
        end
        tick(6);
        rst = 1'b0;
        tick(2);
        for (int n = 0; n < 9; n++) begin
            pause_one(n);
        end
        clr();
        want = 9'h000;
        tick(40);
        chk("no pause on release", 80'h0, 80'(s_ch.size()));
        refresh(0, 10);
        refresh(8, 6);
        busy_resend();
        stamp_ops();
        stamp_b2b();
        conclude();
    end

    initial begin
        #50000;
        error_cnt++;
        conclude();
    end
endmodule : tx_pause_ptp_timestamp_test

`default_nettype wire
